// >>> rtl/cprg_clkdiv.sv
// programmable clock generator: square wave of period 2*ratio cycles
`timescale 1ns/10ps
module cprg_clkdiv (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// control
	input wire logic run,
	input wire logic [cprg_pkg::DIV_W-1:0] ratio,
	// generated clock
	output logic clk_out
);

	logic [cprg_pkg::DIV_W-1:0] cnt;

	// held low while stopped or ratio is zero, so no runt pulses leak out
	always_ff @(posedge ref_clk) begin
		if (!rst_b || !run || ratio == '0) begin
			cnt <= '0;
			clk_out <= 1'b0;
		end else if (cnt >= ratio - cprg_pkg::DIV_RST) begin
			cnt <= '0;
			clk_out <= !clk_out;
		end else begin
			cnt <= cnt + cprg_pkg::DIV_RST;
		end
	end

endmodule

// >>> rtl/cprg_pkg.sv
// constants and types for the clock, pll and reset generation block
// What this block does
// - PLL multiplies reference by firmware factor four through fifteen.
// - system clock bypasses PLL until configured and locked.
// - PLL output times PWM outputs and sources the DSP clock; the DSP divider here ticks on ref_clk.
// - PLL reference is the external reference clock input.
// - separate generators make DSP, S/PDIF, ADC and master clocks.
// - only firmware changes PLL and generator settings.
// - power-on pulse on each rise of PLL supply past threshold.
// - power-on reset drives reset output pin low.
// - core or PWM rail brown-out drives reset output pin low.
// - internal reset from low external reset input or power-on pulse.
// - counter stretches internal reset after external reset release.
// - 3.3V or 1.8V brown-out holds internal reset until both safe.
// - brown-out while running forces safe amplifier shutdown.
// - in reset all resets active, oscillator runs, PLL disabled.
// - on external reset release capture boot pins, then start boot.
package cprg_pkg;

	// ----------------------------------------------------------------
	// pll and clock generators
	// ----------------------------------------------------------------
	localparam int MULT_W = 4;
	localparam logic [3:0] MULT_MIN = 4'h4;
	localparam logic [3:0] MULT_MAX = 4'hF;
	localparam logic [3:0] MULT_RST = 4'h4;
	localparam int DIV_W = 8;
	localparam logic [7:0] DIV_RST = 8'h01;
	localparam int BOOT_W = 4;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int POR_PULSE_NS = 1000;
	localparam int POR_PULSE_CYC = (POR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STRETCH_DEFAULT = 1024;
	localparam int CNT_W = 16;

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CPRG_RS_HOLD = 2'h0,
		CPRG_RS_STRETCH = 2'h1,
		CPRG_RS_RUN = 2'h3
	} cprg_rst_state_t;

	typedef enum logic [1:0] {
		CPRG_PLL_OFF = 2'h0,
		CPRG_PLL_WAIT = 2'h1,
		CPRG_PLL_LOCKED = 2'h3
	} cprg_pll_state_t;

endpackage

// >>> rtl/cprg_sync2.sv
// two-stage level synchroniser, one per bit
`timescale 1ns/10ps
module cprg_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta;

	// first stage feeds only the second stage
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge ref_clk) begin
				if (!rst_b) begin
					meta[i] <= RST_VAL[i];
					q[i] <= RST_VAL[i];
				end else begin
					meta[i] <= d[i];
					q[i] <= meta[i];
				end
			end
		end
	endgenerate

endmodule

// >>> rtl/cprg_top.sv
// clock, pll control and system reset generation top
`timescale 1ns/10ps
module cprg_top #(
	parameter int unsigned STRETCH_CYCLES = cprg_pkg::STRETCH_DEFAULT
) (
	// clock and block reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// board reset and supply sensors
	input wire logic system_reset_in_n,
	input wire logic pll_supply_ok,
	input wire logic core_supply_ok,
	input wire logic io_supply_ok,
	input wire logic pwm_supply_ok,
	// boot selection pins
	input wire logic [cprg_pkg::BOOT_W-1:0] boot_pins,
	// firmware configuration
	input wire logic cfg_load,
	input wire logic cfg_pll_en,
	input wire logic [cprg_pkg::MULT_W-1:0] cfg_pll_mult,
	input wire logic [cprg_pkg::DIV_W-1:0] cfg_dsp_div,
	input wire logic [cprg_pkg::DIV_W-1:0] cfg_spdif_div,
	input wire logic [cprg_pkg::DIV_W-1:0] cfg_adc_div,
	input wire logic [cprg_pkg::DIV_W-1:0] cfg_mclk_div,
	// analog pll macro
	input wire logic pll_lock,
	output logic pll_enable,
	output logic [cprg_pkg::MULT_W-1:0] pll_mult,
	output logic sys_clk_sel,
	output logic pwm_clk_sel,
	// resets and boot
	output logic reset_out_pin_n,
	output logic sys_reset_n,
	output logic [cprg_pkg::BOOT_W-1:0] boot_mode,
	output logic boot_start,
	output logic amp_shutdown,
	// generated clocks
	output logic dsp_clk,
	output logic spdif_clk,
	output logic adc_clk,
	output logic mclk_out
);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic s_ext_n;
	logic s_pll_ok;
	logic s_core_ok;
	logic s_io_ok;
	logic s_pwm_ok;
	logic s_lock;

	// supplies read as bad until sampled, so reset holds from power-up
	cprg_sync2 #(
		.W(6),
		.RST_VAL(6'h00)
	) u_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.d({system_reset_in_n, pll_supply_ok, core_supply_ok, io_supply_ok, pwm_supply_ok, pll_lock}),
		.q({s_ext_n, s_pll_ok, s_core_ok, s_io_ok, s_pwm_ok, s_lock})
	);

	// ----------------------------------------------------------------
	// power-on pulse and brown-out
	// ----------------------------------------------------------------
	logic pll_ok_d;
	logic [cprg_pkg::CNT_W-1:0] por_cnt;
	logic por_active;
	logic bo_hold;
	logic reset_req;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pll_ok_d <= 1'b0;
			por_cnt <= '0;
		end else begin
			pll_ok_d <= s_pll_ok;
			if (s_pll_ok && !pll_ok_d) begin
				por_cnt <= cprg_pkg::CNT_W'(cprg_pkg::POR_PULSE_CYC);
			end else if (por_cnt != '0) begin
				por_cnt <= por_cnt - cprg_pkg::CNT_W'(1);
			end
		end
	end

	// a drooped pll supply counts as power-on reset until the next rise pulse ends
	// the rise cycle itself counts too, before the counter loads, so the pin never blips high
	assign por_active = (por_cnt != '0) || !s_pll_ok || !pll_ok_d;
	assign bo_hold = !s_core_ok || !s_io_ok;
	assign reset_req = !s_ext_n || por_active || bo_hold;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			reset_out_pin_n <= 1'b0;
		end else begin
			reset_out_pin_n <= !(por_active || !s_core_ok || !s_pwm_ok);
		end
	end

	// ----------------------------------------------------------------
	// reset sequencer
	// ----------------------------------------------------------------
	cprg_pkg::cprg_rst_state_t state;
	cprg_pkg::cprg_rst_state_t next_state;
	logic [cprg_pkg::CNT_W-1:0] stretch_cnt;

	always_comb begin
		next_state = state;
		unique case (state)
			cprg_pkg::CPRG_RS_HOLD: begin
				if (!reset_req) begin
					next_state = cprg_pkg::CPRG_RS_STRETCH;
				end
			end
			cprg_pkg::CPRG_RS_STRETCH: begin
				if (reset_req) begin
					next_state = cprg_pkg::CPRG_RS_HOLD;
				end else if (stretch_cnt == cprg_pkg::CNT_W'(STRETCH_CYCLES - 1)) begin
					next_state = cprg_pkg::CPRG_RS_RUN;
				end
			end
			cprg_pkg::CPRG_RS_RUN: begin
				if (reset_req) begin
					next_state = cprg_pkg::CPRG_RS_HOLD;
				end
			end
			default: begin
				next_state = cprg_pkg::CPRG_RS_HOLD;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state <= cprg_pkg::CPRG_RS_HOLD;
			stretch_cnt <= '0;
			sys_reset_n <= 1'b0;
			boot_start <= 1'b0;
		end else begin
			state <= next_state;
			stretch_cnt <= (state == cprg_pkg::CPRG_RS_STRETCH) ? stretch_cnt + cprg_pkg::CNT_W'(1) : '0;
			sys_reset_n <= (next_state == cprg_pkg::CPRG_RS_RUN);
			boot_start <= (state == cprg_pkg::CPRG_RS_STRETCH) && (next_state == cprg_pkg::CPRG_RS_RUN);
		end
	end

	// ----------------------------------------------------------------
	// boot mode capture and amplifier shutdown
	// ----------------------------------------------------------------
	logic ext_d;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ext_d <= 1'b0;
			boot_mode <= '0;
		end else begin
			ext_d <= s_ext_n;
			if (s_ext_n && !ext_d) begin
				boot_mode <= boot_pins;
			end
		end
	end

	// latched so a brief droop cannot let switching resume before reboot
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			amp_shutdown <= 1'b0;
		end else if (state == cprg_pkg::CPRG_RS_RUN && (!s_core_ok || !s_pwm_ok || !s_io_ok)) begin
			amp_shutdown <= 1'b1;
		end else if (boot_start) begin
			amp_shutdown <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// firmware configuration
	// ----------------------------------------------------------------
	logic pll_en_req;
	logic mult_change;
	logic [cprg_pkg::DIV_W-1:0] dsp_div;
	logic [cprg_pkg::DIV_W-1:0] spdif_div;
	logic [cprg_pkg::DIV_W-1:0] adc_div;
	logic [cprg_pkg::DIV_W-1:0] mclk_div;
	logic mult_ok;

	assign mult_ok = cfg_pll_mult >= cprg_pkg::MULT_MIN && cfg_pll_mult <= cprg_pkg::MULT_MAX;

	// settings move only on a firmware load or return to defaults under internal reset; factors out of range are dropped
	always_ff @(posedge ref_clk) begin
		if (!rst_b || !sys_reset_n) begin
			pll_en_req <= 1'b0;
			pll_mult <= cprg_pkg::MULT_RST;
			mult_change <= 1'b0;
			dsp_div <= cprg_pkg::DIV_RST;
			spdif_div <= cprg_pkg::DIV_RST;
			adc_div <= cprg_pkg::DIV_RST;
			mclk_div <= cprg_pkg::DIV_RST;
		end else begin
			mult_change <= 1'b0;
			if (cfg_load) begin
				pll_en_req <= cfg_pll_en;
				dsp_div <= cfg_dsp_div;
				spdif_div <= cfg_spdif_div;
				adc_div <= cfg_adc_div;
				mclk_div <= cfg_mclk_div;
				if (mult_ok) begin
					pll_mult <= cfg_pll_mult;
					mult_change <= (cfg_pll_mult != pll_mult);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// pll lock sequencing
	// ----------------------------------------------------------------
	cprg_pkg::cprg_pll_state_t pll_state;
	cprg_pkg::cprg_pll_state_t next_pll_state;

	// reference for the analog pll is ref_clk itself, from the reference pin
	always_comb begin
		next_pll_state = pll_state;
		unique case (pll_state)
			cprg_pkg::CPRG_PLL_OFF: begin
				if (pll_en_req) begin
					next_pll_state = cprg_pkg::CPRG_PLL_WAIT;
				end
			end
			cprg_pkg::CPRG_PLL_WAIT: begin
				if (!pll_en_req) begin
					next_pll_state = cprg_pkg::CPRG_PLL_OFF;
				end else if (s_lock && !mult_change) begin
					next_pll_state = cprg_pkg::CPRG_PLL_LOCKED;
				end
			end
			cprg_pkg::CPRG_PLL_LOCKED: begin
				if (!pll_en_req) begin
					next_pll_state = cprg_pkg::CPRG_PLL_OFF;
				end else if (!s_lock || mult_change) begin
					next_pll_state = cprg_pkg::CPRG_PLL_WAIT;
				end
			end
			default: begin
				next_pll_state = cprg_pkg::CPRG_PLL_OFF;
			end
		endcase
		if (next_state != cprg_pkg::CPRG_RS_RUN) begin
			next_pll_state = cprg_pkg::CPRG_PLL_OFF;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pll_state <= cprg_pkg::CPRG_PLL_OFF;
			pll_enable <= 1'b0;
			sys_clk_sel <= 1'b0;
			pwm_clk_sel <= 1'b0;
		end else begin
			pll_state <= next_pll_state;
			pll_enable <= (next_pll_state != cprg_pkg::CPRG_PLL_OFF);
			sys_clk_sel <= (next_pll_state == cprg_pkg::CPRG_PLL_LOCKED);
			pwm_clk_sel <= (next_pll_state == cprg_pkg::CPRG_PLL_LOCKED);
		end
	end

	// ----------------------------------------------------------------
	// clock generators
	// ----------------------------------------------------------------
	// dividers tick on ref_clk here; in silicon the same logic sits on the selected source
	cprg_clkdiv u_dsp (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.run(sys_reset_n),
		.ratio(dsp_div),
		.clk_out(dsp_clk)
	);

	cprg_clkdiv u_spdif (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.run(sys_reset_n),
		.ratio(spdif_div),
		.clk_out(spdif_clk)
	);

	cprg_clkdiv u_adc (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.run(sys_reset_n),
		.ratio(adc_div),
		.clk_out(adc_clk)
	);

	cprg_clkdiv u_mclk (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.run(sys_reset_n),
		.ratio(mclk_div),
		.clk_out(mclk_out)
	);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_pll_start;
		$rose(pll_enable);
	endsequence

	sequence s_bypass_two;
		!sys_clk_sel [*2];
	endsequence

	a_por_pulse_len: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(s_pll_ok) |=> (por_active && !reset_out_pin_n) [*8])
		else $error("power-on pulse too short");

	a_por_pin_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
		por_active |=> !reset_out_pin_n)
		else $error("reset pin not low during power-on reset");

	a_brownout_pin: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(!s_core_ok || !s_pwm_ok) |=> !reset_out_pin_n)
		else $error("reset pin not low on brown-out");

	a_ext_reset_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(!s_ext_n || !s_io_ok) |=> !sys_reset_n)
		else $error("internal reset released under reset request");

	a_stretch_count: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(sys_reset_n) |-> $past(state) == cprg_pkg::CPRG_RS_STRETCH
			&& $past(stretch_cnt) == cprg_pkg::CNT_W'(STRETCH_CYCLES - 1))
		else $error("internal reset released before stretch count");

	a_pll_off_reset: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!sys_reset_n |-> !pll_enable && !sys_clk_sel)
		else $error("pll enabled during reset");

	a_bypass_lock: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_pll_start |-> s_bypass_two)
		else $error("pll selected before lock");

	a_mult_range: assert property (@(posedge ref_clk) disable iff (!rst_b)
		pll_mult >= cprg_pkg::MULT_MIN && pll_mult <= cprg_pkg::MULT_MAX)
		else $error("pll factor out of range");

	a_boot_capture: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(s_ext_n) |=> boot_mode == $past(boot_pins))
		else $error("boot mode not captured on release");

	a_amp_shutdown: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(state == cprg_pkg::CPRG_RS_RUN && !s_pwm_ok) |=> amp_shutdown)
		else $error("no amplifier shutdown on brown-out");

	a_pwm_follows: assert property (@(posedge ref_clk) disable iff (!rst_b)
		pwm_clk_sel == sys_clk_sel)
		else $error("pwm clock source differs from system clock source");

endmodule

// >>> tb/cprg_partner.sv
// board reset source, supply sensors and analog pll model
`timescale 1ns/10ps
module cprg_partner #(
	parameter int LOCK_DLY = 30
) (
	// clock
	input wire logic ref_clk,
	// bench commands
	input wire logic ext_hold,
	input wire logic pll_pwr,
	input wire logic core_pwr,
	input wire logic io_pwr,
	input wire logic pwm_pwr,
	// pll control from the block
	input wire logic pll_enable,
	input wire logic [cprg_pkg::MULT_W-1:0] pll_mult,
	// board levels
	output logic system_reset_in_n,
	output logic pll_supply_ok,
	output logic core_supply_ok,
	output logic io_supply_ok,
	output logic pwm_supply_ok,
	output logic pll_lock
);
	logic [cprg_pkg::MULT_W-1:0] last_mult;
	int lock_cnt;

	assign system_reset_in_n = !ext_hold;
	assign pll_supply_ok = pll_pwr;
	assign core_supply_ok = core_pwr;
	assign io_supply_ok = io_pwr;
	assign pwm_supply_ok = pwm_pwr;

	// -------------------------------------------------
	// lock model
	// -------------------------------------------------
	// slow lock, lost on any factor change, like a real loop relocking
	always_ff @(posedge ref_clk) begin
		last_mult <= pll_mult;
		if (!pll_enable || pll_mult !== last_mult)
			lock_cnt <= 0;
		else if (lock_cnt < LOCK_DLY)
			lock_cnt <= lock_cnt + 1;
	end
	assign pll_lock = (lock_cnt == LOCK_DLY);
endmodule

// >>> tb/cprg_top_tb.sv
// self-checking bench for the clock, pll and reset block
`timescale 1ns/10ps
module cprg_top_tb;
	localparam int STR = 8;
	localparam int O_SYS = 0;
	localparam int O_ROUT = 1;
	localparam int O_SEL = 2;
	localparam int O_BOOT = 3;
	localparam int O_AMP = 4;
	logic ref_clk = 0;
	logic rst_b = 0;
	logic ext_hold = 1, pll_pwr = 0, core_pwr = 0, io_pwr = 0, pwm_pwr = 0;
	logic system_reset_in_n, pll_supply_ok, core_supply_ok, io_supply_ok, pwm_supply_ok, pll_lock;
	logic [3:0] boot_pins = 4'h0;
	logic cfg_load = 0;
	logic cfg_pll_en = 0;
	logic [3:0] cfg_pll_mult = 4'h4;
	logic [7:0] dv [4] = '{8'h01, 8'h01, 8'h01, 8'h01};
	logic pll_enable, sys_clk_sel, pwm_clk_sel, reset_out_pin_n, sys_reset_n, boot_start, amp_shutdown;
	logic dsp_clk, spdif_clk, adc_clk, mclk_out;
	logic [3:0] pll_mult, boot_mode, em;
	logic [3:0] boot_exp = 4'h0;
	wire [4:0] obs = {amp_shutdown, boot_start, sys_clk_sel, reset_out_pin_n, sys_reset_n};
	wire [3:0] gclk = {mclk_out, adc_clk, spdif_clk, dsp_clk};
	int bad_count = 0;
	int cmp_count = 0;
	integer seed = 32'h25c7;
	logic [7:0] exp_q [$];

	cprg_top #(.STRETCH_CYCLES(STR)) cprg_top_inst (.ref_clk(ref_clk), .rst_b(rst_b),
		.system_reset_in_n(system_reset_in_n), .pll_supply_ok(pll_supply_ok), .core_supply_ok(core_supply_ok),
		.io_supply_ok(io_supply_ok), .pwm_supply_ok(pwm_supply_ok), .boot_pins(boot_pins),
		.cfg_load(cfg_load), .cfg_pll_en(cfg_pll_en), .cfg_pll_mult(cfg_pll_mult), .cfg_dsp_div(dv[0]),
		.cfg_spdif_div(dv[1]), .cfg_adc_div(dv[2]), .cfg_mclk_div(dv[3]), .pll_lock(pll_lock),
		.pll_enable(pll_enable), .pll_mult(pll_mult), .sys_clk_sel(sys_clk_sel), .pwm_clk_sel(pwm_clk_sel),
		.reset_out_pin_n(reset_out_pin_n), .sys_reset_n(sys_reset_n), .boot_mode(boot_mode),
		.boot_start(boot_start), .amp_shutdown(amp_shutdown), .dsp_clk(dsp_clk), .spdif_clk(spdif_clk),
		.adc_clk(adc_clk), .mclk_out(mclk_out));

	cprg_partner cprg_partner_inst (.ref_clk(ref_clk), .ext_hold(ext_hold), .pll_pwr(pll_pwr),
		.core_pwr(core_pwr), .io_pwr(io_pwr), .pwm_pwr(pwm_pwr), .pll_enable(pll_enable), .pll_mult(pll_mult),
		.system_reset_in_n(system_reset_in_n), .pll_supply_ok(pll_supply_ok), .core_supply_ok(core_supply_ok),
		.io_supply_ok(io_supply_ok), .pwm_supply_ok(pwm_supply_ok), .pll_lock(pll_lock));

	initial begin
		forever #25 ref_clk = ~ref_clk;
	end

	// -------------------------------------------------
	// helpers
	// -------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		if (bad_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic wait_for(input int idx, input logic val, input int max);
		int n;
		n = 0;
		while (obs[idx] !== val && n < max) begin
			@(negedge ref_clk);
			n++;
		end
		if (obs[idx] !== val) begin
			bad_count++;
			$display("wrong value at %0t: wait timed out on %0d", $time, idx);
			final_report();
		end
	endtask

	// boot pins are only resampled on a board reset release, not on a supply reboot
	task automatic arm(input bit ext_rel);
		if (ext_rel)
			boot_exp = boot_pins;
		exp_q.push_back({4'h0, boot_exp});
	endtask

	// pins move after capture so a late resample would show
	task automatic done;
		wait_for(O_BOOT, 1'b1, 80);
		boot_pins = 4'($random(seed));
	endtask

	task automatic load(input logic [3:0] m, input logic en);
		cfg_pll_mult = m;
		cfg_pll_en = en;
		cfg_load = 1;
		tick(1);
		cfg_load = 0;
	endtask

	task automatic half(input int i);
		logic p;
		int n;
		for (int k = 0; k < 2; k++) begin
			p = gclk[i];
			n = 0;
			while (gclk[i] === p && n < 40) begin
				@(negedge ref_clk);
				n++;
			end
		end
		check(8'(n), dv[i]);
	endtask

	// boot mode seen whenever the internal reset releases
	always @(negedge ref_clk) begin
		if (boot_start === 1'b1) begin
			if (exp_q.size() == 0)
				check(8'hFF, 8'h00);
			else
				check({4'h0, boot_mode}, exp_q.pop_front());
		end
	end

	// -------------------------------------------------
	// main sequence
	// -------------------------------------------------
	initial begin
		tick(12);
		rst_b = 1;
		tick(3);
		check(sys_reset_n, 0);
		check(pll_enable, 0);
		check(pll_mult, 4);
		pll_pwr = 1;
		core_pwr = 1;
		io_pwr = 1;
		pwm_pwr = 1;
		boot_pins = 4'($random(seed));
		tick(10);
		check(reset_out_pin_n, 0);
		tick(20);
		check(reset_out_pin_n, 1);
		check(sys_reset_n, 0);
		// board reset bounces during the stretch: count must restart
		arm(1'b1);
		ext_hold = 0;
		tick(5);
		ext_hold = 1;
		tick(2);
		ext_hold = 0;
		tick(STR);
		check(sys_reset_n, 0);
		done();
		for (int i = 0; i < 4; i++)
			dv[i] = 8'(1 + ($random(seed) & 7));
		em = 4'h4;
		for (int m = 0; m < 16; m++) begin
			load(m[3:0], 1);
			if (m >= 4)
				em = m[3:0];
			tick(2);
			check(pll_mult, em);
			check(sys_clk_sel, 0);
		end
		wait_for(O_SEL, 1'b1, 60);
		check(pwm_clk_sel, 1);
		check(pll_enable, 1);
		for (int i = 0; i < 4; i++)
			half(i);
		load(4'hF, 0);
		tick(3);
		check(pll_enable, 0);
		check(sys_clk_sel, 0);
		pwm_pwr = 0;
		wait_for(O_AMP, 1'b1, 8);
		check(reset_out_pin_n, 0);
		pwm_pwr = 1;
		wait_for(O_ROUT, 1'b1, 8);
		check(amp_shutdown, 1);
		check(sys_reset_n, 1);
		core_pwr = 0;
		wait_for(O_SYS, 1'b0, 8);
		check(reset_out_pin_n, 0);
		arm(1'b0);
		core_pwr = 1;
		done();
		tick(1);
		check(amp_shutdown, 0);
		io_pwr = 0;
		wait_for(O_SYS, 1'b0, 8);
		check(reset_out_pin_n, 1);
		arm(1'b0);
		io_pwr = 1;
		done();
		pll_pwr = 0;
		wait_for(O_ROUT, 1'b0, 8);
		wait_for(O_SYS, 1'b0, 8);
		tick(3);
		arm(1'b0);
		pll_pwr = 1;
		tick(10);
		check(reset_out_pin_n, 0);
		done();
		check(reset_out_pin_n, 1);
		ext_hold = 1;
		tick(1);
		check(sys_reset_n, 1);
		wait_for(O_SYS, 1'b0, 6);
		arm(1'b1);
		ext_hold = 0;
		done();
		tick(5);
		check(8'(exp_q.size()), 0);
		final_report();
	end
endmodule
